// ==== logic/tvi_cpu_end.sv ====
`timescale 1ns/10ps
`default_nettype none
module tvi_cpu_end import tvi_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// instruction sequencer side
	input wire logic instrDone,
	input wire logic retiExec,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	output logic callStart,
	output logic callBusy,
	output logic [15:0] callVector,
	// handler link
	tvi_if.sequencer link
);
	tvi_cpu_state_t state;
	logic [2:0] callCnt;
	logic taking;

	// a call starts at the edge where an instruction end meets a request
	assign taking = link.instrEnd & link.irqReq;

	////////////////////////////////////////////////////////////////
	// forced call sequencer, four cycles long
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= CS_RUN;
			callCnt <= 3'h0;
			callStart <= 1'b0;
			callBusy <= 1'b0;
			callVector <= VEC_BASE;
		end else begin
			callStart <= 1'b0;
			case (state)
				CS_RUN: begin
					if (taking) begin
						state <= CS_CALL;
						callCnt <= CALL_CYCLES - 3'h1;
						callStart <= 1'b1;
						callBusy <= 1'b1;
						callVector <= link.irqVector;
					end
				end
				CS_CALL: begin
					if (callCnt == 3'h0) begin
						state <= CS_RUN;
						callBusy <= 1'b0;
					end else begin
						callCnt <= callCnt - 3'h1;
					end
				end
				default: begin
					state <= CS_RUN;
					callBusy <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// instruction boundaries; a return is reported on its own strobe
	// so the handler never treats it as an ordinary boundary
	// return strobe to the handler
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.instrEnd <= 1'b0;
			link.retiDone <= 1'b0;
		end else begin
			link.instrEnd <= instrDone & (state == CS_RUN) & ~taking & ~retiExec;
			link.retiDone <= retiExec & (state == CS_RUN) & ~taking;
		end
	end

	// register access passes through one flop each way
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.sfrWr <= 1'b0;
			link.sfrAddr <= REG_RESET;
			link.sfrWdata <= REG_RESET;
			sfrRdata <= REG_RESET;
		end else begin
			link.sfrWr <= sfrWrite;
			link.sfrAddr <= sfrAddr;
			link.sfrWdata <= sfrWdata;
			sfrRdata <= link.sfrRdata;
		end
	end
endmodule
`default_nettype wire

// ==== logic/tvi_ext_input.sv ====
`timescale 1ns/10ps
`default_nettype none
module tvi_ext_input import tvi_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pin selection and sense
	input wire logic [7:0] portPins,
	input wire logic [2:0] pinSel,
	input wire logic activeHigh,
	// conditioned input
	output logic active,
	output logic activeEdge
);
	logic syncA;
	logic syncB;
	logic level;

	////////////////////////////////////////////////////////////////
	// two-stage synchroniser on the picked pin; only observes it,
	// so whatever peripheral owns the pin is left alone
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end else begin
			syncA <= portPins[pinSel];
			syncB <= syncA;
		end
	end

	// polarity applied after the second stage only
	assign level = activeHigh ? syncB : ~syncB;

	// level and inactive-to-active transition
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			active <= 1'b0;
			activeEdge <= 1'b0;
		end else begin
			active <= level;
			activeEdge <= level & ~active;
		end
	end
endmodule
`default_nettype wire

// ==== logic/tvi_handler.sv ====
`timescale 1ns/10ps
`default_nettype none
module tvi_handler import tvi_pkg::*; #(
	parameter logic [15:0] HW_CLEAR_MASK = HW_CLR_MASK
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// peripheral events and port pins
	input wire logic [15:0] periphEvent,
	input wire logic [7:0] portPins,
	// pending flags as seen by peripherals
	output logic [15:0] pendingOut,
	// sequencer link
	tvi_if.handler cpu
);
	logic [7:0] ieReg;
	logic [7:0] eie1Reg;
	logic [7:0] eie2Reg;
	logic [7:0] ipReg;
	logic [7:0] eip1Reg;
	logic [7:0] eip2Reg;
	logic [7:0] pinCfg;
	logic trigA;
	logic trigB;
	logic [15:0] pendFlag;
	logic [15:0] next_pendFlag;
	logic [15:0] pendView;
	logic [15:0] enables;
	logic [15:0] prios;
	logic [15:0] reqs;
	logic [15:0] clrMask;
	logic [4:0] hiPick;
	logic [4:0] loPick;
	logic [3:0] irqSrc;
	logic next_irqReq;
	logic next_irqHigh;
	logic [3:0] next_irqSrc;
	logic inSvcHi;
	logic inSvcLo;
	logic actA;
	logic actB;
	logic edgeA;
	logic edgeB;
	logic vectoring;

	// lowest-numbered set bit wins; msb of result flags a hit
	function automatic logic [4:0] firstSrc(input logic [15:0] r);
		logic [4:0] res;
		res = 5'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (r[i]) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////
	// external inputs
	// pin select and sense
	tvi_ext_input extA (
		.sys_clk(sys_clk),
		.rst(rst),
		.portPins(portPins),
		.pinSel(pinCfg[PINA_LSB +: 3]),
		.activeHigh(pinCfg[POLA_BIT]),
		.active(actA),
		.activeEdge(edgeA)
	);

	tvi_ext_input extB (
		.sys_clk(sys_clk),
		.rst(rst),
		.portPins(portPins),
		.pinSel(pinCfg[PINB_LSB +: 3]),
		.activeHigh(pinCfg[POLB_BIT]),
		.active(actB),
		.activeEdge(edgeB)
	);

	////////////////////////////////////////////////////////////////
	// configuration registers
	// priorities reset to low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ieReg <= REG_RESET;
			eie1Reg <= REG_RESET;
			eie2Reg <= REG_RESET;
			ipReg <= REG_RESET;
			eip1Reg <= REG_RESET;
			eip2Reg <= REG_RESET;
			pinCfg <= REG_RESET;
			trigA <= 1'b0;
			trigB <= 1'b0;
		end else if (cpu.sfrWr) begin
			case (cpu.sfrAddr)
				ADDR_IE: ieReg <= cpu.sfrWdata;
				ADDR_EIE1: eie1Reg <= cpu.sfrWdata;
				ADDR_EXTENDED_IRQ_ENABLE_REG2: eie2Reg <= cpu.sfrWdata;
				ADDR_IP: ipReg <= cpu.sfrWdata;
				ADDR_EIP1: eip1Reg <= cpu.sfrWdata;
				ADDR_EXTENDED_IRQ_PRIORITY_REG2: eip2Reg <= cpu.sfrWdata;
				ADDR_PINCFG: pinCfg <= cpu.sfrWdata;
				ADDR_TIMER_CONTROL_REG: begin
					trigA <= cpu.sfrWdata[EXTA_TRIG_BIT];
					trigB <= cpu.sfrWdata[EXTB_TRIG_BIT];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// pending flags
	// level mode shows the live input instead of the stored flag
	always_comb begin
		pendView = pendFlag;
		if (!trigA) begin
			pendView[EXTA_SRC] = actA;
		end
		if (!trigB) begin
			pendView[EXTB_SRC] = actB;
		end
	end

	// edge-mode external flags join the auto-clear set
	always_comb begin
		clrMask = HW_CLEAR_MASK;
		clrMask[EXTA_SRC] = trigA;
		clrMask[EXTB_SRC] = trigB;
	end

	assign vectoring = cpu.instrEnd & cpu.irqReq;

	// software writes first, hardware clear next, events last so a set wins
	always_comb begin
		next_pendFlag = pendFlag;
		if (cpu.sfrWr) begin
			case (cpu.sfrAddr)
				// a written one is a real request
				ADDR_PEND_LO: next_pendFlag[7:0] = cpu.sfrWdata;
				ADDR_PEND_HI: next_pendFlag[15:8] = cpu.sfrWdata;
				ADDR_TIMER_CONTROL_REG: begin
					next_pendFlag[EXTA_SRC] = cpu.sfrWdata[EXTA_PEND_BIT];
					next_pendFlag[EXTB_SRC] = cpu.sfrWdata[EXTB_PEND_BIT];
				end
				default: ;
			endcase
		end
		// hardware clear only for the listed sources
		if (vectoring && clrMask[irqSrc]) begin
			next_pendFlag[irqSrc] = 1'b0;
		end
		next_pendFlag = next_pendFlag | periphEvent;
		// edges count only in edge mode; the synchroniser leaves reset
		// low, which would otherwise leave a stale hidden flag behind
		next_pendFlag[EXTA_SRC] = next_pendFlag[EXTA_SRC] | (edgeA & trigA);
		next_pendFlag[EXTB_SRC] = next_pendFlag[EXTB_SRC] | (edgeB & trigB);
	end

	// stored flags
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pendFlag <= PEND_RESET;
		end else begin
			pendFlag <= next_pendFlag;
		end
	end

	////////////////////////////////////////////////////////////////
	// request resolution
	assign enables = {eie2Reg[0], eie1Reg, ieReg[6:0]};
	assign prios = {eip2Reg[0], eip1Reg, ipReg[6:0]};
	assign reqs = pendView & enables & {NUM_SRC{ieReg[GLOBAL_EN_BIT]}};
	// split by level, fixed order inside each
	assign hiPick = firstSrc(reqs & prios);
	assign loPick = firstSrc(reqs & ~prios);

	// low may be preempted by high, high by nothing
	// equal level waits for the running routine
	always_comb begin
		next_irqReq = 1'b0;
		next_irqHigh = 1'b0;
		next_irqSrc = 4'h0;
		if (hiPick[4] && !inSvcHi) begin
			next_irqReq = 1'b1;
			next_irqHigh = 1'b1;
			next_irqSrc = hiPick[3:0];
		end else if (loPick[4] && !inSvcHi && !inSvcLo) begin
			next_irqReq = 1'b1;
			next_irqSrc = loPick[3:0];
		end
	end

	// one cycle of detect, re-decoded every cycle
	// registered request still reflects the enable of the cycle before
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpu.irqReq <= 1'b0;
			cpu.irqHigh <= 1'b0;
			irqSrc <= 4'h0;
			cpu.irqVector <= VEC_BASE;
		end else begin
			cpu.irqReq <= next_irqReq;
			cpu.irqHigh <= next_irqHigh;
			irqSrc <= next_irqSrc;
			// eight-byte spacing from the first vector
			cpu.irqVector <= VEC_BASE + 16'({next_irqSrc, 3'b000});
		end
	end

	////////////////////////////////////////////////////////////////
	// in-service levels; a return pops the innermost level
	// taken at an instruction end with a live request
	// return and instruction end are distinct events, so a
	// still-pending flag is re-taken only after one more instruction
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			inSvcHi <= 1'b0;
			inSvcLo <= 1'b0;
		end else if (vectoring) begin
			if (cpu.irqHigh) begin
				inSvcHi <= 1'b1;
			end else begin
				inSvcLo <= 1'b1;
			end
		end else if (cpu.retiDone) begin
			if (inSvcHi) begin
				inSvcHi <= 1'b0;
			end else begin
				inSvcLo <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// register read-back, one cycle behind the address
	// all flags readable, level-mode external bits as the live input
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpu.sfrRdata <= REG_RESET;
		end else begin
			case (cpu.sfrAddr)
				ADDR_IE: cpu.sfrRdata <= ieReg;
				ADDR_EIE1: cpu.sfrRdata <= eie1Reg;
				ADDR_EXTENDED_IRQ_ENABLE_REG2: cpu.sfrRdata <= eie2Reg;
				ADDR_IP: cpu.sfrRdata <= ipReg;
				ADDR_EIP1: cpu.sfrRdata <= eip1Reg;
				ADDR_EXTENDED_IRQ_PRIORITY_REG2: cpu.sfrRdata <= eip2Reg;
				ADDR_PINCFG: cpu.sfrRdata <= pinCfg;
				ADDR_PEND_LO: cpu.sfrRdata <= pendView[7:0];
				ADDR_PEND_HI: cpu.sfrRdata <= pendView[15:8];
				ADDR_TIMER_CONTROL_REG: cpu.sfrRdata <= {4'h0, pendView[EXTB_SRC], trigB,
					pendView[EXTA_SRC], trigA};
				default: cpu.sfrRdata <= REG_RESET;
			endcase
		end
	end

	// peripherals see the flags one cycle late
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pendingOut <= PEND_RESET;
		end else begin
			pendingOut <= pendView;
		end
	end
endmodule
`default_nettype wire

// ==== logic/tvi_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface tvi_if;
	// handler to sequencer
	logic irqReq;
	logic irqHigh;
	logic [15:0] irqVector;
	logic [7:0] sfrRdata;
	// sequencer to handler
	logic instrEnd;
	logic retiDone;
	logic sfrWr;
	logic [7:0] sfrAddr;
	logic [7:0] sfrWdata;
	modport handler (
		output irqReq, irqHigh, irqVector, sfrRdata,
		input instrEnd, retiDone, sfrWr, sfrAddr, sfrWdata
	);
	modport sequencer (
		input irqReq, irqHigh, irqVector, sfrRdata,
		output instrEnd, retiDone, sfrWr, sfrAddr, sfrWdata
	);
endinterface
`default_nettype wire

// ==== logic/tvi_pkg.sv ====
`default_nettype none
package tvi_pkg;
	// source count and register map
	localparam int NUM_SRC = 16;
	localparam logic [7:0] ADDR_IE = 8'hA8;
	localparam logic [7:0] ADDR_IP = 8'hB8;
	localparam logic [7:0] ADDR_EIE1 = 8'hE6;
	localparam logic [7:0] ADDR_EXTENDED_IRQ_ENABLE_REG2 = 8'hE7;
	localparam logic [7:0] ADDR_EIP1 = 8'hF6;
	localparam logic [7:0] ADDR_EXTENDED_IRQ_PRIORITY_REG2 = 8'hF7;
	localparam logic [7:0] ADDR_TIMER_CONTROL_REG = 8'h88;
	localparam logic [7:0] ADDR_PINCFG = 8'hE4;
	localparam logic [7:0] ADDR_PEND_LO = 8'h9A;
	localparam logic [7:0] ADDR_PEND_HI = 8'h9B;
	// field positions
	localparam int GLOBAL_EN_BIT = 7;
	localparam int EXTA_TRIG_BIT = 0;
	localparam int EXTA_PEND_BIT = 1;
	localparam int EXTB_TRIG_BIT = 2;
	localparam int EXTB_PEND_BIT = 3;
	localparam int PINA_LSB = 0;
	localparam int POLA_BIT = 3;
	localparam int PINB_LSB = 4;
	localparam int POLB_BIT = 7;
	localparam int EXTA_SRC = 0;
	localparam int EXTB_SRC = 2;
	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] PEND_RESET = 16'h0000;
	// sources cleared by hardware on vectoring regardless of mode (timer overflows)
	localparam logic [15:0] HW_CLR_MASK = 16'h000A;
	// vectors and timing
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam int VEC_SHIFT = 3;
	localparam logic [2:0] CALL_CYCLES = 3'h4;
	// sequencer states
	typedef enum logic [1:0] {
		CS_RUN = 2'b01,
		CS_CALL = 2'b10
	} tvi_cpu_state_t;
endpackage
`default_nettype wire

// ==== verif/tvi_handler_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module tvi_handler_bench import tvi_pkg::*; ();
	logic sys_clk, rst, instrDone, retiExec, sfrWrite, callStart, callBusy;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata, portPins, rdVal, ipVal;
	logic [15:0] periphEvent, pendingOut, callVector, evMask;
	logic [7:0] regs [7] = '{ADDR_IE, ADDR_IP, ADDR_EIE1, ADDR_EXTENDED_IRQ_ENABLE_REG2, ADDR_EIP1, ADDR_PINCFG, 8'h01};
	int n_errors, checked, s, k;
	tvi_if linkIf ();
	tvi_handler tvi_handler_inst (.sys_clk(sys_clk), .rst(rst), .periphEvent(periphEvent),
		.portPins(portPins), .pendingOut(pendingOut), .cpu(linkIf));
	tvi_cpu_end tvi_cpu_end_inst (.sys_clk(sys_clk), .rst(rst), .instrDone(instrDone),
		.retiExec(retiExec), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
		.sfrRdata(sfrRdata), .callStart(callStart), .callBusy(callBusy),
		.callVector(callVector), .link(linkIf));
	tvi_monitor tvi_monitor_inst (.sys_clk(sys_clk), .rst(rst), .irqReq(linkIf.irqReq),
		.irqHigh(linkIf.irqHigh), .irqVector(linkIf.irqVector), .sfrRdata(linkIf.sfrRdata),
		.instrEnd(linkIf.instrEnd), .retiDone(linkIf.retiDone), .sfrWr(linkIf.sfrWr),
		.sfrAddr(linkIf.sfrAddr), .sfrWdata(linkIf.sfrWdata));
	////////////////////////////////////////////////////////////////////////////////
	// compare and report
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input string what);
		check_word({15'h0000, got}, {15'h0000, exp}, what);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	function automatic logic [15:0] vecOf(input int src);
		return VEC_BASE + 16'(src * 8);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// register write, two edges so back to back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfrWrite <= 1'b1;
		sfrAddr <= a;
		sfrWdata <= d;
		@(posedge sys_clk);
		sfrWrite <= 1'b0;
	endtask
	// read data shows three edges after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		sfrAddr <= a;
		repeat (3) @(posedge sys_clk);
		#1 d = sfrRdata;
	endtask
	// one instruction or return boundary, spaced so a fresh request is visible
	task automatic step(input logic isReti);
		repeat (4) @(posedge sys_clk);
		if (isReti) begin
			retiExec <= 1'b1;
		end else begin
			instrDone <= 1'b1;
		end
		@(posedge sys_clk);
		retiExec <= 1'b0;
		instrDone <= 1'b0;
	endtask
	// watch a window long enough for call plus busy time
	task automatic take(input logic expSeen, input logic [15:0] expVec);
		logic seen;
		logic [15:0] vec;
		int busyCnt;
		seen = 1'b0;
		vec = 16'h0000;
		busyCnt = 0;
		repeat (12) begin
			@(negedge sys_clk);
			if (callBusy === 1'b1) begin
				busyCnt++;
			end
			if (callStart === 1'b1 && !seen) begin
				seen = 1'b1;
				vec = callVector;
			end
		end
		check_bit(seen, expSeen, "call seen");
		if (expSeen) begin
			check_word(vec, expVec, "call vector");
			check_word(16'(busyCnt), 16'(CALL_CYCLES), "busy cycles");
		end
	endtask
	// pin 3 to a level, other pins random, then let the synchroniser settle
	task automatic pin(input logic v);
		@(posedge sys_clk);
		portPins <= (8'($urandom) & 8'hF7) | {4'h0, v, 3'h0};
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// whole run is about 1100 cycles, this is well over ten times that
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		instrDone = 1'b0;
		retiExec = 1'b0;
		sfrWrite = 1'b0;
		sfrAddr = 8'h00;
		sfrWdata = 8'h00;
		portPins = 8'hFF;
		periphEvent = 16'h0000;
		n_errors = 0;
		checked = 0;
		void'($urandom(67));
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i], rdVal);
			check_word({8'h00, rdVal}, 16'h0000, "reset read");
		end
		check_word(pendingOut, PEND_RESET, "reset flags");
		ipVal = 8'($urandom);
		wr(ADDR_IP, ipVal);
		rd(ADDR_IP, rdVal);
		check_word({9'h000, rdVal[6:0]}, {9'h000, ipVal[6:0]}, "prio read");
		wr(ADDR_IP, 8'h00);
		$display("test reset done");
		// every peripheral source: latch, global gate, call, clear
		wr(ADDR_IE, 8'h7F);
		wr(ADDR_EIE1, 8'hFF);
		wr(ADDR_EXTENDED_IRQ_ENABLE_REG2, 8'h01);
		for (s = 1; s < NUM_SRC; s++) begin
			if (s != 2) begin
				if ($urandom % 2) begin
					wr(s < 8 ? ADDR_PEND_LO : ADDR_PEND_HI, 8'(1 << (s % 8)));
				end else begin
					@(posedge sys_clk);
					periphEvent <= 16'(1 << s);
					@(posedge sys_clk);
					periphEvent <= 16'h0000;
				end
				repeat (3) @(posedge sys_clk);
				#1 check_bit(pendingOut[s], 1'b1, "flag set");
				step(1'b0);
				take(1'b0, 16'h0000);
				wr(ADDR_IE, 8'hFF);
				step(1'b0);
				take(1'b1, vecOf(s));
				check_bit(pendingOut[s], !HW_CLR_MASK[s], "flag after call");
				if (s == 4) begin
					step(1'b1);
					step(1'b0);
					take(1'b1, vecOf(s));
				end
				wr(ADDR_IE, 8'h7F);
				wr(s < 8 ? ADDR_PEND_LO : ADDR_PEND_HI, 8'h00);
				step(1'b1);
			end
		end
		$display("test sources done");
		// individual enables off with the global one on
		wr(ADDR_IE, 8'h80);
		wr(ADDR_EIE1, 8'h00);
		wr(ADDR_EXTENDED_IRQ_ENABLE_REG2, 8'h00);
		evMask = (16'($urandom) & 16'hFFFA) | 16'h0010;
		@(posedge sys_clk);
		periphEvent <= evMask;
		@(posedge sys_clk);
		periphEvent <= 16'h0000;
		step(1'b0);
		take(1'b0, 16'h0000);
		check_word(pendingOut & 16'hFFFA, evMask, "masked flags");
		$display("test masked done");
		// two levels: 4 and 9 high, 5 12 13 low
		wr(ADDR_EIE1, 8'hFF);
		wr(ADDR_EIP1, 8'h04);
		wr(ADDR_IP, 8'h10);
		wr(ADDR_PEND_LO, 8'h30);
		wr(ADDR_PEND_HI, 8'h32);
		wr(ADDR_IE, 8'hFF);
		step(1'b0);
		take(1'b1, vecOf(4));
		step(1'b0);
		take(1'b0, 16'h0000);
		wr(ADDR_PEND_LO, 8'h20);
		step(1'b1);
		take(1'b0, 16'h0000);
		step(1'b0);
		take(1'b1, vecOf(9));
		wr(ADDR_PEND_HI, 8'h30);
		step(1'b1);
		step(1'b0);
		take(1'b1, vecOf(5));
		step(1'b0);
		take(1'b0, 16'h0000);
		wr(ADDR_IP, 8'h40);
		wr(ADDR_PEND_LO, 8'h60);
		step(1'b0);
		take(1'b1, vecOf(6));
		wr(ADDR_PEND_LO, 8'h00);
		step(1'b1);
		step(1'b1);
		step(1'b0);
		take(1'b1, vecOf(12));
		wr(ADDR_PEND_HI, 8'h00);
		step(1'b1);
		$display("test priority done");
		// external input on pin 3, all four sense combinations, requests off
		wr(ADDR_IE, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(ADDR_TIMER_CONTROL_REG, {7'h00, k[1]});
			wr(ADDR_PINCFG, {4'h0, k[0], 3'h3});
			pin(!k[0]);
			wr(ADDR_PEND_LO, 8'h00);
			repeat (3) @(posedge sys_clk);
			#1 check_bit(pendingOut[0], 1'b0, "ext idle");
			pin(k[0]);
			check_bit(pendingOut[0], 1'b1, "ext active");
			pin(!k[0]);
			check_bit(pendingOut[0], k[1], "ext released");
		end
		// edge mode flag drops on vectoring
		wr(ADDR_TIMER_CONTROL_REG, 8'h01);
		wr(ADDR_PINCFG, 8'h0B);
		wr(ADDR_PEND_LO, 8'h00);
		wr(ADDR_IE, 8'h81);
		pin(1'b1);
		step(1'b0);
		take(1'b1, VEC_BASE);
		check_bit(pendingOut[0], 1'b0, "edge flag cleared");
		step(1'b1);
		$display("test external done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ==== verif/tvi_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module tvi_monitor import tvi_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// handler to sequencer
	input wire logic irqReq,
	input wire logic irqHigh,
	input wire logic [15:0] irqVector,
	input wire logic [7:0] sfrRdata,
	// sequencer to handler
	input wire logic instrEnd,
	input wire logic retiDone,
	input wire logic sfrWr,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata
);
	default clocking monClk @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// a boundary meeting an offered request is a take
	sequence takeHi;
		instrEnd && irqReq && irqHigh;
	endsequence
	sequence takeLo;
		instrEnd && irqReq && !irqHigh;
	endsequence
	// priority write followed by a read of the same place
	sequence prioWrRd;
		sfrWr && sfrAddr == ADDR_IP ##1 sfrAddr == ADDR_IP && !sfrWr;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// offered vectors sit on the eight byte grid below 0x80
	vec_grid_a: assert property (irqReq |-> irqVector[2:0] == 3'h3 && !irqVector[15:7])
		else $error("offered vector off grid");
	// reset must not be disabled by itself here
	reset_idle_a: assert property (disable iff (1'b0)
		rst |=> !irqReq && !irqHigh && irqVector == VEC_BASE)
		else $error("link not idle after reset");
	global_off_a: assert property (sfrWr && sfrAddr == ADDR_IE && !sfrWdata[7] |-> ##2 !irqReq)
		else $error("request survives global disable");
	// in-service marking lands on the take edge and drops the request two edges after the take
	high_hold_a: assert property (takeHi ##1 !retiDone ##1 1'b1 |-> !irqReq)
		else $error("high routine preempted");
	low_wait_a: assert property (takeLo ##1 !retiDone ##1 1'b1 |-> !irqReq || irqHigh)
		else $error("equal level request not held");
	return_from_irq_alone_a: assert property (retiDone |-> !instrEnd)
		else $error("return shares a boundary");
	unmapped_zero_a: assert property (sfrAddr == 8'h01 |=> sfrRdata == 8'h00)
		else $error("unmapped read not zero");
	prio_back_a: assert property (prioWrRd |=> sfrRdata[6:0] == $past(sfrWdata[6:0], 2))
		else $error("priority readback wrong");
endmodule
`default_nettype wire
